// ---- ptp_timer.sv ----
// Purpose: 10-bit phase correct pwm timer with clock select control
// Assumes: registers over plain strobe port, read data one cycle later
// Notes: pwm high while count below compare; dead time bits stored only
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "ptp_params.svh"
module ptp_timer #(
  parameter int CNT_W = 10,
  parameter int PRE_W = 14
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic pwm_output_pin
);
  ptp_pkg::ptp_ctrl_t ctrl_ff;
  ptp_pkg::ptp_ctrl_t nxt_ctrl;
  logic [CNT_W-1:0] top_ff;
  logic [CNT_W-1:0] nxt_top;
  logic [CNT_W-1:0] cmp_ff;
  logic [CNT_W-1:0] nxt_cmp;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  ptp_pkg::ptp_dir_t dir_ff;
  ptp_pkg::ptp_dir_t nxt_dir;
  logic pwm_ff;
  logic nxt_pwm;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic tick;

  ////////////////////////////////////////////////////////////////////////
  // prescaler
  ptp_prescaler #(
    .PRE_W(PRE_W)
  ) ptp_prescaler_inst (
    .mclk(mclk),
    .rst_b(rst_b),
    .clock_select(ctrl_ff.clock_select),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // register file
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_top = top_ff;
    nxt_cmp = cmp_ff;
    nxt_rdata = `PTP_RD_ZERO;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `PTP_OFS_CTRL: nxt_ctrl = reg_wdata[7:0];
        `PTP_OFS_TOP: nxt_top = reg_wdata[CNT_W-1:0];
        `PTP_OFS_CMP: nxt_cmp = reg_wdata[CNT_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        `PTP_OFS_CTRL: nxt_rdata = {8'h00, ctrl_ff};
        `PTP_OFS_TOP: nxt_rdata = 16'(top_ff);
        `PTP_OFS_CMP: nxt_rdata = 16'(cmp_ff);
        `PTP_OFS_CNT: nxt_rdata = 16'(cnt_ff);
        default: nxt_rdata = `PTP_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ctrl_ff <= `PTP_CTRL_RST;
      top_ff <= `PTP_TOP_RST;
      cmp_ff <= `PTP_CMP_RST;
      rdata_ff <= `PTP_RD_ZERO;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      top_ff <= nxt_top;
      cmp_ff <= nxt_cmp;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // up/down counter, moves only on a prescaler tick
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    nxt_pwm = pwm_ff;
    if (tick)
    begin
      nxt_pwm = (cnt_ff < cmp_ff);
      unique case (dir_ff)
        ptp_pkg::PTP_UP:
        begin
          if (cnt_ff >= top_ff)
          begin
            nxt_dir = ptp_pkg::PTP_DOWN;
            if (cnt_ff != `PTP_CNT_RST)
            begin
              nxt_cnt = cnt_ff - `PTP_CNT_ONE;
            end
          end
          else
          begin
            nxt_cnt = cnt_ff + `PTP_CNT_ONE;
          end
        end
        ptp_pkg::PTP_DOWN:
        begin
          if (cnt_ff == `PTP_CNT_RST)
          begin
            nxt_dir = ptp_pkg::PTP_UP;
            if (top_ff != `PTP_CNT_RST)
            begin
              nxt_cnt = `PTP_CNT_ONE;
            end
          end
          else
          begin
            nxt_cnt = cnt_ff - `PTP_CNT_ONE;
          end
        end
      endcase
    end
  end

  // top lowered below the count just turns the counter downward
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cnt_ff <= `PTP_CNT_RST;
      dir_ff <= ptp_pkg::PTP_UP;
      pwm_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      dir_ff <= nxt_dir;
      pwm_ff <= nxt_pwm;
    end
  end

  assign pwm_output_pin = pwm_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks on registered state, each looks one edge ahead
  a_stop_frozen: assert property (@(posedge mclk) disable iff (!rst_b)
    ctrl_ff.clock_select == `PTP_CS_STOP |=> $stable(cnt_ff) &&
    $stable(pwm_ff))
    else $error("counter moved while stopped");
  a_hold_no_tick: assert property (@(posedge mclk) disable iff (!rst_b)
    !tick |=> $stable(cnt_ff) && $stable(dir_ff))
    else $error("counter changed without a tick");
  a_turn_at_top: assert property (@(posedge mclk) disable iff (!rst_b)
    tick && dir_ff == ptp_pkg::PTP_UP && cnt_ff == top_ff &&
    top_ff != `PTP_CNT_RST |=> dir_ff == ptp_pkg::PTP_DOWN &&
    cnt_ff == $past(top_ff) - `PTP_CNT_ONE)
    else $error("no turn at top");
  a_turn_at_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    tick && dir_ff == ptp_pkg::PTP_DOWN && cnt_ff == `PTP_CNT_RST &&
    top_ff != `PTP_CNT_RST |=> dir_ff == ptp_pkg::PTP_UP &&
    cnt_ff == `PTP_CNT_ONE)
    else $error("no turn at zero");
  a_ctrl_write: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_wr && reg_addr == `PTP_OFS_CTRL |=>
    ctrl_ff == $past(reg_wdata[7:0]))
    else $error("control write lost");
  a_cnt_read: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_rd && reg_addr == `PTP_OFS_CNT |=>
    reg_rdata == 16'($past(cnt_ff)))
    else $error("count read back wrong");
  a_pwm_compare: assert property (@(posedge mclk) disable iff (!rst_b)
    tick |=> pwm_output_pin == ($past(cnt_ff) < $past(cmp_ff)))
    else $error("pwm level not from compare");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == `PTP_RD_ZERO)
    else $error("read data left standing");
  a_up_step: assert property (@(posedge mclk) disable iff (!rst_b)
    tick && dir_ff == ptp_pkg::PTP_UP && cnt_ff < top_ff |=>
    dir_ff == ptp_pkg::PTP_UP && cnt_ff == $past(cnt_ff) + `PTP_CNT_ONE)
    else $error("count did not step up");
  a_down_step: assert property (@(posedge mclk) disable iff (!rst_b)
    tick && dir_ff == ptp_pkg::PTP_DOWN && cnt_ff != `PTP_CNT_RST |=>
    dir_ff == ptp_pkg::PTP_DOWN && cnt_ff == $past(cnt_ff) - `PTP_CNT_ONE)
    else $error("count did not step down");
  a_ctrl_keep: assert property (@(posedge mclk) disable iff (!rst_b)
    !(reg_wr && reg_addr == `PTP_OFS_CTRL) |=> $stable(ctrl_ff))
    else $error("control changed without a write");
  a_pwm_no_tick: assert property (@(posedge mclk) disable iff (!rst_b)
    !tick |=> $stable(pwm_ff))
    else $error("pwm level moved without a tick");
  a_top_write: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_wr && reg_addr == `PTP_OFS_TOP |=>
    top_ff == $past(reg_wdata[CNT_W-1:0]))
    else $error("top write lost");
  a_cmp_write: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_wr && reg_addr == `PTP_OFS_CMP |=>
    cmp_ff == $past(reg_wdata[CNT_W-1:0]))
    else $error("compare write lost");
endmodule // ptp_timer

// ---- ptp_params.svh ----
// Purpose: named offsets, reset values and codes for the pwm timer
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef PTP_PARAMS_SVH
`define PTP_PARAMS_SVH
`define PTP_OFS_CTRL 8'h00
`define PTP_OFS_TOP 8'h01
`define PTP_OFS_CMP 8'h02
`define PTP_OFS_CNT 8'h03
`define PTP_CTRL_RST 8'h07
`define PTP_TOP_RST 10'h0FF
`define PTP_CMP_RST 10'h000
`define PTP_CNT_RST 10'h000
`define PTP_CNT_ONE 10'h001
`define PTP_CS_STOP 4'h0
`define PTP_CS_DIV1 4'h1
`define PTP_CS_DIV2 4'h2
`define PTP_PRE_RST 14'h0000
`define PTP_PRE_ONE 14'h0001
`define PTP_RD_ZERO 16'h0000
`endif

// ---- ptp_pkg.sv ----
// Purpose: shared types of the pwm timer
// Assumes: nothing
// Notes: control register layout msb first
package ptp_pkg;
  typedef struct packed {
    logic pwm_mode_bit;
    logic prescaler_reset_bit;
    logic dead_time_prescale_hi;
    logic dead_time_prescale_lo;
    logic [3:0] clock_select;
  } ptp_ctrl_t;
  typedef enum logic {PTP_UP, PTP_DOWN} ptp_dir_t;
endpackage

// ---- ptp_prescaler.sv ----
// Purpose: power of two clock prescaler giving a one-cycle tick
// Assumes: single clock mclk, synchronous active low reset
// Notes: tick is combinational from the divider state
`timescale 1ns/10ps
`include "ptp_params.svh"
module ptp_prescaler #(
  parameter int PRE_W = 14
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] clock_select,
  output logic tick
);
  logic [PRE_W-1:0] pre_ff;
  logic [PRE_W-1:0] nxt_pre;
  logic [PRE_W-1:0] mask;

  ////////////////////////////////////////////////////////////////////////
  // ratio 2**(code-1): bit i takes part when code exceeds i+1
  genvar gi;
  generate
    for (gi = 0; gi < PRE_W; gi++)
    begin : g_mask
      assign mask[gi] = (32'(clock_select) > (gi + 1));
    end
  endgenerate

  // divider runs freely except under the stop code, which clears it; a new nonzero code changes the mask at once
  assign tick = (clock_select != `PTP_CS_STOP) &&
                ((pre_ff & mask) == mask);

  always_comb
  begin
    nxt_pre = pre_ff + `PTP_PRE_ONE;
    if (clock_select == `PTP_CS_STOP)
    begin
      nxt_pre = `PTP_PRE_RST;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pre_ff <= `PTP_PRE_RST;
    end
    else
    begin
      pre_ff <= nxt_pre;
    end
  end

  a_div1_every: assert property (@(posedge mclk) disable iff (!rst_b)
    clock_select == `PTP_CS_DIV1 |-> tick)
    else $error("divide by one missed a tick");
  a_div2_alt: assert property (@(posedge mclk) disable iff (!rst_b)
    (clock_select == `PTP_CS_DIV2 && tick) ##1
    (clock_select == `PTP_CS_DIV2) |-> !tick)
    else $error("divide by two ticked twice in a row");
  a_stop_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
    clock_select == `PTP_CS_STOP |-> !tick)
    else $error("tick while stopped");
endmodule // ptp_prescaler

// ---- ptp_drv_model.sv ----
// Purpose: driver input model timing the pwm pin
// Assumes: one clock mclk, synchronous active low reset
// Notes: reports last full period and its high time in cycles
`timescale 1ns/10ps
module ptp_drv_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pwm_in,
  output int period,
  output int high_cnt
);
  int run;
  int hi;
  logic last;
  // a period runs from one rising edge of the pin to the next
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      run = 0;
      hi = 0;
      last = 1'b0;
      period <= 0;
      high_cnt <= 0;
    end
    else
    begin
      run++;
      if (pwm_in) hi++;
      if (pwm_in && !last)
      begin
        period <= run - 1;
        high_cnt <= hi - 1;
        run = 1;
        hi = 1;
      end
      last = pwm_in;
    end
  end
endmodule // ptp_drv_model

// ---- ptp_timer_bench.sv ----
// Purpose: self-checking bench of the pwm timer
// Assumes: 10 MHz mclk, register port with read data one cycle later
// Notes: count read back over the port to measure tick rates
`timescale 1ns/10ps
`include "ptp_params.svh"
module ptp_timer_bench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic pwm_output_pin;
  logic [15:0] d0;
  logic [15:0] d1;
  logic p0;
  int period;
  int high_cnt;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [39:0] rows [4] = '{40'h00_FFF5_00F5, 40'h01_FFFF_03FF,
    40'h02_0480_0080, 40'h04_00AA_0000};
  always #50 mclk = ~mclk;
  ptp_timer ptp_timer_inst (.mclk(mclk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm_output_pin(pwm_output_pin));
  ptp_drv_model ptp_drv_model_inst (.mclk(mclk), .rst_b(rst_b),
    .pwm_in(pwm_output_pin), .period(period), .high_cnt(high_cnt));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, sampled mid-cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // longest path is the slow select codes, about 40k cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    chk("pin_rst", {15'h0000, pwm_output_pin}, 16'h0000);
    rd(`PTP_OFS_CTRL, d0);
    chk("ctrl_rst", d0, {8'h00, `PTP_CTRL_RST});
    rd(`PTP_OFS_TOP, d0);
    chk("top_rst", d0, {6'h00, `PTP_TOP_RST});
    rd(`PTP_OFS_CMP, d0);
    chk("cmp_rst", d0, {6'h00, `PTP_CMP_RST});
    // read data stand one cycle only, then fall back to zero
    @(negedge mclk);
    chk("rdata_idle", reg_rdata, `PTP_RD_ZERO);
    foreach (rows[i])
    begin
      wr(rows[i][39:32], rows[i][31:16]);
      rd(rows[i][39:32], d0);
      chk("reg_rw", d0, rows[i][15:0]);
    end
    // stop code freezes count and pin
    wr(`PTP_OFS_CTRL, 16'h0000);
    rd(`PTP_OFS_CNT, d0);
    // count is read only, a write to it must not land
    wr(`PTP_OFS_CNT, 16'h0155);
    p0 = pwm_output_pin;
    repeat (300) @(posedge mclk);
    rd(`PTP_OFS_CNT, d1);
    chk("stop_cnt", d1, d0);
    chk("stop_pin", {15'h0000, pwm_output_pin}, {15'h0000, p0});
    // tick rate per select code, count kept across changes
    for (int n = 1; n < 16; n++)
    begin
      wr(`PTP_OFS_CTRL, 16'(n));
      rd(`PTP_OFS_CNT, d0);
      repeat (((n < 10) ? 8 : 1) * (1 << (n - 1)) - 2) @(posedge mclk);
      rd(`PTP_OFS_CNT, d1);
      chk("tick_rate", d1 - d0, (n < 10) ? 16'h0008 : 16'h0001);
    end
    wr(`PTP_OFS_TOP, 16'h00FF);
    wr(`PTP_OFS_CMP, 16'h0080);
    wr(`PTP_OFS_CTRL, 16'h0001);
    repeat (1600) @(posedge mclk);
    chk("pwm_period", 16'(period), 16'h01FE);
    chk("pwm_high", 16'(high_cnt), 16'h00FF);
    // reset again in mid-run, while the pin toggles
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk("pin_rst2", {15'h0000, pwm_output_pin}, 16'h0000);
    rd(`PTP_OFS_CTRL, d0);
    chk("ctrl_rst2", d0, {8'h00, `PTP_CTRL_RST});
    rd(`PTP_OFS_CNT, d0);
    chk("cnt_rst2", d0, {6'h00, `PTP_CNT_RST});
    complete_run;
  end
endmodule // ptp_timer_bench
